// >>> design/count_edge_source.sv
`timescale 1ns/10ps
module count_edge_source
   import gated_timer_pkg::*;
(
   // Clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // Pins
   input  wire logic       ext_clock_in,
   input  wire logic       crystal_in_pin,
   input  wire logic       gate_input,
   // Counter side
   edge_source_if.edge_side link
);

   logic [2:0] meta;
   logic [2:0] sync;
   logic [1:0] retimed;
   logic       level_prev;
   logic       level;
   logic       rise;
   logic       crystal_level;

   // Two-stage synchronisers for pin, crystal and gate
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         meta <= 3'h0;
         sync <= 3'h0;
      end else begin
         meta <= {gate_input, crystal_in_pin, ext_clock_in};
         sync <= meta;
      end
   end

   // Extra stage aligns clocks to the phase clocks in synchronous mode
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         retimed <= 2'h0;
      end else begin
         retimed <= sync[1:0];
      end
   end

   // Bypass skips the retiming stage, so a mode switch can drop or add one edge
   always_comb begin
      crystal_level = link.crystal_osc_enable &
                      (link.sync_bypass ? sync[1] : retimed[1]);
      level = 1'b0;
      unique case (link.source)
         SRC_PIN:     level = link.sync_bypass ? sync[0] : retimed[0];
         SRC_CRYSTAL: level = crystal_level;
         SRC_SYSTEM:  level = 1'b0;
         SRC_NONE:    level = 1'b0;
      endcase
   end

   // Edge memory for rising-edge detection
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         level_prev <= 1'b0;
      end else begin
         level_prev <= level;
      end
   end

   assign rise = level & ~level_prev;

   // Synchronous counting stops in sleep, bypassed external counting goes on
   always_comb begin
      link.tick = 1'b0;
      unique case (link.source)
         SRC_SYSTEM:  link.tick = ~link.sleep;
         SRC_PIN:     link.tick = rise & (link.sync_bypass | ~link.sleep);
         SRC_CRYSTAL: link.tick = rise & (link.sync_bypass | ~link.sleep);
         SRC_NONE:    link.tick = 1'b0;
      endcase
   end

   assign link.gate_level = sync[2];

   // Inverting amplifier drive for the crystal, quiet when disabled
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         link.crystal_drive <= 1'b0;
      end else begin
         link.crystal_drive <= link.crystal_osc_enable & ~sync[1];
      end
   end

endmodule

// >>> design/edge_source_if.sv
`timescale 1ns/10ps
interface edge_source_if;
   import gated_timer_pkg::*;

   clock_source_e source;
   logic          sync_bypass;
   logic          crystal_osc_enable;
   logic          sleep;
   logic          tick;
   logic          gate_level;
   logic          crystal_drive;

   modport counter (
      output source,
      output sync_bypass,
      output crystal_osc_enable,
      output sleep,
      input  tick,
      input  gate_level,
      input  crystal_drive
   );

   modport edge_side (
      input  source,
      input  sync_bypass,
      input  crystal_osc_enable,
      input  sleep,
      output tick,
      output gate_level,
      output crystal_drive
   );
endinterface

// >>> design/gated_sixteen_bit_timer.sv
// Contract
// - Counter is one 16-bit value shown as high and low byte registers.
// - Two-bit prescale select divides the counter input clock by 1, 2, 4 or 8.
// - Prescale counter is hidden; writing either count byte clears it.
// - Oscillator enable starts the 32.768 kHz crystal source, which runs through sleep.
// - Overflow flag sets on rollover; software may preload FC00h to check the crystal.
// - Sync bypass counts the external clock without phase-clock synchronisation.
// - Bypassed external counting continues in sleep; overflow interrupt wakes the processor.
// - Mode switches may lose or add one increment.
// - Count byte reads while counting externally always return a valid byte.
// - With gating off the counter counts on every prescaled clock event.
// - Gate enable turns on gating; gate polarity picks the counting gate level.
// - While the gate allows counting, count on each rising clock edge.
// - Count when gate input equals polarity; hold the value otherwise.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module gated_sixteen_bit_timer
   import gated_timer_pkg::*;
#(
   parameter int unsigned COUNT_WIDTH    = 16,
   parameter int unsigned PRESCALE_WIDTH = 3
)
(
   // Clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_b_in,
   // Avalon-MM slave
   input  wire logic [BUS_ADDR_W-1:0] avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [BUS_DATA_W-1:0] avs_writedata_in,
   input  wire logic [3:0]            avs_byteenable_in,
   output logic      [BUS_DATA_W-1:0] avs_readdata_out,
   output logic                       avs_waitrequest_out,
   // Counter pins
   input  wire logic                  ext_clock_in,
   input  wire logic                  crystal_in_pin,
   output logic                       crystal_out_pin,
   input  wire logic                  gate_input,
   // Power state and interrupt
   input  wire logic                  sleep_in,
   output logic                       irq_out
);

   // Byte-wide register view only fits a 16-bit counter and 3-bit prescaler
   if (COUNT_WIDTH != 16) begin
      $error("COUNT_WIDTH must be 16");
   end
   if (PRESCALE_WIDTH != 3) begin
      $error("PRESCALE_WIDTH must be 3");
   end

   // Every control field must sit in the one byte that the bus writes
   if (CTRL_SOURCE_LSB > 6 || CTRL_PRESCALE_LSB > 6) begin
      $error("timer control fields leave the byte");
   end
   if (GATE_EN_BIT > 7 || GATE_POL_BIT > 7 || GATE_LEVEL_BIT != 0) begin
      $error("gate control fields leave the byte");
   end
   if (IRQ_OVERFLOW_BIT > 7) begin
      $error("overflow bit leaves the byte");
   end

   // Read data carries at least one byte, offsets fit the address
   if (BUS_DATA_W < 8) begin
      $error("bus data narrower than a byte");
   end
   if (BUS_ADDR_W != 8) begin
      $error("offsets are eight bits wide");
   end
   if (OFS_COUNT_LOW == OFS_COUNT_HIGH) begin
      $error("count bytes share an offset");
   end

   edge_source_if link ();

   // Register state, software-visible apart from the prescale count
   logic [7:0]                timer_control_reg;
   logic [7:0]                gate_control_reg;
   logic [COUNT_WIDTH-1:0]    count;
   logic [PRESCALE_WIDTH-1:0] prescale_count;
   logic                      overflow_flag;
   logic                      overflow_mask;

   // Bus handshake
   logic                      ack;
   logic                      bus_request;
   logic                      write_strobe;
   logic                      low_lane_write;

   // Decoded control fields
   logic                      timer_on;
   logic                      sync_bypass;
   logic                      crystal_osc_enable;
   logic [1:0]                prescale_select;
   logic                      gate_enable;
   logic                      gate_polarity;

   // Count path and read data
   logic                      gate_open;
   logic                      count_event;
   logic [PRESCALE_WIDTH-1:0] prescale_limit;
   logic                      prescale_done;
   logic                      increment;
   logic                      overflow_event;
   logic                      count_low_write;
   logic                      count_high_write;
   logic [BUS_DATA_W-1:0]     next_readdata;

   // Address selects
   logic                      sel_count_low;
   logic                      sel_count_high;
   logic                      sel_timer_ctrl;
   logic                      sel_gate_ctrl;
   logic                      sel_irq_status;
   logic                      sel_irq_mask;

   // Write strobes, next count and byte views
   logic                      timer_ctrl_write;
   logic                      gate_ctrl_write;
   logic                      mask_write;
   logic                      overflow_clear;
   logic [COUNT_WIDTH-1:0]    next_count;
   logic [7:0]                count_low_byte;
   logic [7:0]                count_high_byte;

   // Field decode
   assign timer_on           = timer_control_reg[CTRL_TIMER_ON_BIT];
   assign sync_bypass        = timer_control_reg[CTRL_SYNC_BYP_BIT];
   assign crystal_osc_enable = timer_control_reg[CTRL_OSC_EN_BIT];
   assign prescale_select    = timer_control_reg[CTRL_PRESCALE_LSB +: 2];
   assign gate_enable        = gate_control_reg[GATE_EN_BIT];
   assign gate_polarity      = gate_control_reg[GATE_POL_BIT];

   // Settings toward the edge source
   assign link.source             = clock_source_e'(timer_control_reg[CTRL_SOURCE_LSB +: 2]);
   assign link.sync_bypass        = sync_bypass;
   assign link.crystal_osc_enable = crystal_osc_enable;
   assign link.sleep              = sleep_in;

   count_edge_source u_edge (
      .clock_in       (clock_in),
      .rst_b_in       (rst_b_in),
      .ext_clock_in   (ext_clock_in),
      .crystal_in_pin (crystal_in_pin),
      .gate_input     (gate_input),
      .link           (link)
   );

   assign crystal_out_pin = link.crystal_drive;

   // Avalon handshake: one wait cycle, then the request is taken
   assign bus_request         = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = bus_request & ~ack;
   assign write_strobe        = avs_write_in & ack;
   assign low_lane_write      = write_strobe & avs_byteenable_in[0];
   assign count_low_write     = low_lane_write & sel_count_low;
   assign count_high_write    = low_lane_write & sel_count_high;
   assign timer_ctrl_write    = low_lane_write & sel_timer_ctrl;
   assign gate_ctrl_write     = low_lane_write & sel_gate_ctrl;
   assign mask_write          = low_lane_write & sel_irq_mask;
   assign overflow_clear      = low_lane_write & sel_irq_status
                              & avs_writedata_in[IRQ_OVERFLOW_BIT];

   // Address decode, one select per mapped register
   assign sel_count_low       = (avs_address_in == OFS_COUNT_LOW);
   assign sel_count_high      = (avs_address_in == OFS_COUNT_HIGH);
   assign sel_timer_ctrl      = (avs_address_in == OFS_TIMER_CTRL);
   assign sel_gate_ctrl       = (avs_address_in == OFS_GATE_CTRL);
   assign sel_irq_status      = (avs_address_in == OFS_IRQ_STATUS);
   assign sel_irq_mask        = (avs_address_in == OFS_IRQ_MASK);

   // Acknowledge lasts one cycle; a request held past it is taken again every second cycle
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_request & ~ack;
      end
   end

   // Timer control register
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         timer_control_reg <= TIMER_CTRL_RESET;
      end else if (timer_ctrl_write) begin
         timer_control_reg <= avs_writedata_in[7:0];
      end
   end

   // Gate control register, level bit is read-only
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         gate_control_reg <= GATE_CTRL_RESET;
      end else if (gate_ctrl_write) begin
         gate_control_reg <= {avs_writedata_in[7:1], 1'b0};
      end
   end

   // Gate: free running when disabled, else gate must match polarity
   assign gate_open = ~gate_enable
                    | (link.gate_level == gate_polarity);

   // A gated-off clock edge is dropped before the prescaler
   assign count_event = timer_on & gate_open & link.tick;

   // Prescale terminal value for divide by 1, 2, 4 or 8
   always_comb begin
      unique case (prescale_select)
         2'b00: prescale_limit = 3'h0;
         2'b01: prescale_limit = 3'h1;
         2'b10: prescale_limit = 3'h3;
         2'b11: prescale_limit = 3'h7;
      endcase
   end

   assign prescale_done = (prescale_count >= prescale_limit);
   assign increment     = count_event & prescale_done;

   // Prescaler is not mapped; a count byte write restarts it
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         prescale_count <= PRESCALE_RESET;
      end else if (count_low_write || count_high_write) begin
         prescale_count <= PRESCALE_RESET;
      end else if (count_event) begin
         if (prescale_done) begin
            prescale_count <= PRESCALE_RESET;
         end else begin
            prescale_count <= prescale_count + 3'h1;
         end
      end
   end

   assign overflow_event = increment & (&count);

   // Plain binary carry, so the high byte steps on a low-byte rollover
   assign next_count     = count + 16'h0001;

   // Counter; a byte write wins over a coinciding increment
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         count <= COUNT_RESET;
      end else if (count_low_write) begin
         count[7:0] <= avs_writedata_in[7:0];
      end else if (count_high_write) begin
         count[15:8] <= avs_writedata_in[7:0];
      end else if (increment) begin
         count <= next_count;
      end
   end

   // Overflow status, write one to clear; a new overflow beats the clear
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         overflow_flag <= 1'b0;
      end else if (overflow_event) begin
         overflow_flag <= 1'b1;
      end else if (overflow_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   // Interrupt mask
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         overflow_mask <= 1'b0;
      end else if (mask_write) begin
         overflow_mask <= avs_writedata_in[IRQ_OVERFLOW_BIT];
      end
   end

   // Level interrupt doubles as the wake request in sleep
   assign irq_out = overflow_flag & overflow_mask;

   // Byte views of the one count value
   assign count_low_byte  = count[7:0];
   assign count_high_byte = count[15:8];

   // Read mux; unmapped offsets read as zero
   always_comb begin
      next_readdata = '0;
      unique case (avs_address_in)
         OFS_COUNT_LOW:  next_readdata[7:0] = count_low_byte;
         OFS_COUNT_HIGH: next_readdata[7:0] = count_high_byte;
         OFS_TIMER_CTRL: next_readdata[7:0] = timer_control_reg;
         OFS_GATE_CTRL:  next_readdata[7:0] = {gate_control_reg[7:1], link.gate_level};
         OFS_IRQ_STATUS: next_readdata[IRQ_OVERFLOW_BIT] = overflow_flag;
         OFS_IRQ_MASK:   next_readdata[IRQ_OVERFLOW_BIT] = overflow_mask;
         default:        next_readdata = '0;
      endcase
   end

   // Read data registered in the wait cycle, so a byte is never torn
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         avs_readdata_out <= '0;
      end else if (avs_read_in && !ack) begin
         avs_readdata_out <= next_readdata;
      end
   end

endmodule

// >>> design/gated_timer_pkg.sv
package gated_timer_pkg;

   // Bus geometry
   localparam int unsigned BUS_ADDR_W = 8;
   localparam int unsigned BUS_DATA_W = 32;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFS_COUNT_LOW   = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04;
   localparam logic [7:0] OFS_TIMER_CTRL  = 8'h08;
   localparam logic [7:0] OFS_GATE_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;

   // Timer control field positions
   localparam int unsigned CTRL_TIMER_ON_BIT  = 0;
   localparam int unsigned CTRL_SYNC_BYP_BIT  = 2;
   localparam int unsigned CTRL_OSC_EN_BIT    = 3;
   localparam int unsigned CTRL_PRESCALE_LSB  = 4;
   localparam int unsigned CTRL_SOURCE_LSB    = 6;

   // Gate control field positions
   localparam int unsigned GATE_LEVEL_BIT     = 0;
   localparam int unsigned GATE_POL_BIT       = 6;
   localparam int unsigned GATE_EN_BIT        = 7;

   // Interrupt bit positions
   localparam int unsigned IRQ_OVERFLOW_BIT   = 0;

   // Reset values
   localparam logic [7:0]  TIMER_CTRL_RESET   = 8'h00;
   localparam logic [7:0]  GATE_CTRL_RESET    = 8'h00;
   localparam logic [15:0] COUNT_RESET        = 16'h0000;
   localparam logic [2:0]  PRESCALE_RESET     = 3'h0;

   // Counter clock source choices
   typedef enum logic [1:0] {
      SRC_SYSTEM   = 2'b00,
      SRC_PIN      = 2'b01,
      SRC_CRYSTAL  = 2'b10,
      SRC_NONE     = 2'b11
   } clock_source_e;

endpackage

// >>> tb/gated_timer_assertions.sv
`timescale 1ns/10ps
module gated_timer_assertions
   import gated_timer_pkg::*;
(
   // Watched ports
   input  wire logic                  clock_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [BUS_DATA_W-1:0] avs_readdata_out,
   input  wire logic                  avs_waitrequest_out,
   input  wire logic                  crystal_in_pin,
   input  wire logic                  crystal_out_pin,
   input  wire logic                  irq_out
);
   default clocking main_cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   wire req = avs_read_in | avs_write_in;

   // Bus handshake: exactly one wait cycle
   a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
      else $error("no wait cycle on a new request");
   a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("wait cycle too long");
   a_wait_idle: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest while idle");
   // Byte registers leave upper bits clear
   a_upper_zero: assert property (avs_read_in && !avs_waitrequest_out |->
      avs_readdata_out[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_data_stands: assert property (!avs_read_in |=> $stable(avs_readdata_out))
      else $error("read data moved without a read");
   // Interrupt quiet out of reset, drops only by a write
   a_reset_quiet: assert property ($rose(rst_b_in) |-> !irq_out && avs_readdata_out == '0)
      else $error("outputs not clear after reset");
   a_irq_holds: assert property (irq_out && !avs_write_in |=> irq_out)
      else $error("interrupt dropped without a write");
   // Inverter drive: a high crystal input forces drive low
   a_crystal_drive: assert property (crystal_in_pin [*4] |=> !crystal_out_pin)
      else $error("crystal drive not inverted");
endmodule

bind gated_sixteen_bit_timer gated_timer_assertions chk (
   .clock_in            (clock_in),
   .rst_b_in            (rst_b_in),
   .avs_read_in         (avs_read_in),
   .avs_write_in        (avs_write_in),
   .avs_readdata_out    (avs_readdata_out),
   .avs_waitrequest_out (avs_waitrequest_out),
   .crystal_in_pin      (crystal_in_pin),
   .crystal_out_pin     (crystal_out_pin),
   .irq_out             (irq_out)
);

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import gated_timer_pkg::*;
   logic                  clock_in;
   logic                  rst_b;
   logic [BUS_ADDR_W-1:0] address;
   logic                  read;
   logic                  write;
   logic [BUS_DATA_W-1:0] wdata;
   logic [3:0]            be;
   logic [BUS_DATA_W-1:0] rdata;
   logic                  waitreq;
   logic                  ext_clk;
   logic                  xtal_in;
   logic                  xtal_out;
   logic                  gate;
   logic                  gate_cmd;
   logic                  ext_run;
   logic                  sleep;
   logic                  irq;
   logic [15:0]           c;
   int                    err_count    = 0;
   int                    total_checks = 0;
   int                    edges        = 0;
   int                    cycles       = 0;

   gated_sixteen_bit_timer DUT (
      .clock_in(clock_in), .rst_b_in(rst_b), .avs_address_in(address),
      .avs_read_in(read), .avs_write_in(write), .avs_writedata_in(wdata),
      .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .ext_clock_in(ext_clk), .crystal_in_pin(xtal_in), .crystal_out_pin(xtal_out),
      .gate_input(gate), .sleep_in(sleep), .irq_out(irq)
   );
   timer_pins_model pins (
      .clock_in(clock_in), .ext_run_in(ext_run), .gate_level_in(gate_cmd),
      .crystal_out_pin(xtal_out), .ext_clock_out(ext_clk), .crystal_in_pin(xtal_in),
      .gate_out(gate)
   );

   // 10 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   // Hang guard, well above the crystal wait
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_count++;
         conclude();
      end
   end

   // Rising edges handed to the counter
   always @(posedge ext_clk) edges++;

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon cycle; held until waitrequest is seen low, then a free edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      address <= a;
      wdata <= {24'h000000, d};
      read <= !wr;
      write <= wr;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (waitreq !== 1'b0);
      q = rdata;
      check("wait cycles", n, 32'h2);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clock_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(name, q, exp);
   endtask

   // Caller stops the timer first, so the two byte writes cannot collide
   task automatic preload(input logic [15:0] v);
      wr(OFS_COUNT_LOW, v[7:0]);
      wr(OFS_COUNT_HIGH, v[15:8]);
   endtask

   // Low byte first; only safe while stopped, as the low byte may roll
   task automatic rdcount(output logic [15:0] v);
      logic [31:0] q;
      bus(1'b0, OFS_COUNT_LOW, 8'h00, q);
      v[7:0] = q[7:0];
      bus(1'b0, OFS_COUNT_HIGH, 8'h00, q);
      v[15:8] = q[7:0];
   endtask

   task automatic ctrl(input logic on, input logic [1:0] ps, input logic [1:0] src,
                       input logic byp, input logic osc);
      wr(OFS_TIMER_CTRL, {src, ps, osc, byp, 1'b0, on});
   endtask

   initial begin
      {address, wdata, read, write, ext_run, gate_cmd, sleep, rst_b} = '0;
      be = 4'h1;
      repeat (4) @(posedge clock_in);
      rst_b <= 1'b1;
      @(posedge clock_in);
      // Reset values, unmapped slot included
      for (int i = 0; i < 7; i++)
         rd(8'(i * 4), 32'h0, "reset value");
      wr(8'h18, 8'hff);
      rd(8'h18, 32'h0, "unmapped");
      // Byte halves of one count; disabled lane ignored
      preload(16'ha55a);
      be <= 4'h0;
      wr(OFS_COUNT_LOW, 8'h11);
      be <= 4'h1;
      rdcount(c);
      check("count pair", 32'(c), 32'ha55a);
      // Four divide ratios over about 65 clocks, prescaler cleared by preload
      for (int p = 0; p < 4; p++) begin
         preload(16'h0000);
         ctrl(1'b1, 2'(p), 2'b00, 1'b0, 1'b0);
         repeat (62) @(posedge clock_in);
         ctrl(1'b0, 2'(p), 2'b00, 1'b0, 1'b0);
         rdcount(c);
         check("prescale", 32'(c >= (64 >> p) - 1 && c <= (64 >> p) + 2), 32'h1);
      end
      // Three divide-by-8 events, a low byte write, six more: no increment
      preload(16'h0000);
      for (int k = 0; k < 3; k++) begin
         if (k == 1)
            wr(OFS_COUNT_LOW, 8'h00);
         ctrl(1'b1, 2'b11, 2'b00, 1'b0, 1'b0);
         ctrl(1'b0, 2'b11, 2'b00, 1'b0, 1'b0);
      end
      rdcount(c);
      check("prescale clear", 32'(c), 32'h0);
      // Rollover sets the flag, wraps, masks and clears
      wr(OFS_IRQ_MASK, 8'h01);
      preload(16'hfffe);
      ctrl(1'b1, 2'b00, 2'b00, 1'b0, 1'b0);
      repeat (6) @(posedge clock_in);
      check("irq on", 32'(irq), 32'h1);
      ctrl(1'b0, 2'b00, 2'b00, 1'b0, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h1, "flag");
      rdcount(c);
      check("wrap", 32'(c < 16'h0010), 32'h1);
      wr(OFS_IRQ_MASK, 8'h00);
      check("masked", 32'(irq), 32'h0);
      wr(OFS_IRQ_STATUS, 8'h01);
      rd(OFS_IRQ_STATUS, 32'h0, "clear");
      // Every gate enable, polarity and pin level
      for (int g = 0; g < 8; g++) begin
         gate_cmd <= g[0];
         preload(16'h0000);
         wr(OFS_GATE_CTRL, {g[2], g[1], 6'h00});
         rd(OFS_GATE_CTRL, {24'h0, g[2], g[1], 5'h00, g[0]}, "gate reg");
         ctrl(1'b1, 2'b00, 2'b00, 1'b0, 1'b0);
         repeat (20) @(posedge clock_in);
         ctrl(1'b0, 2'b00, 2'b00, 1'b0, 1'b0);
         rdcount(c);
         check("gate", 32'(c != 0), 32'(!g[2] || g[1] == g[0]));
      end
      // Pin clock in sleep: synchronous mode stops, bypass keeps counting
      for (int b = 0; b < 2; b++) begin
         preload(16'h0000);
         ctrl(1'b1, 2'b00, 2'b01, b[0], 1'b0);
         edges = 0;
         sleep <= 1'b1;
         ext_run <= 1'b1;
         repeat (100) @(posedge clock_in);
         ext_run <= 1'b0;
         repeat (8) @(posedge clock_in);
         sleep <= 1'b0;
         ctrl(1'b0, 2'b00, 2'b01, b[0], 1'b0);
         rdcount(c);
         check("pin count", 32'(b ? (c + 1 >= edges && c <= edges) : c == 0), 32'h1);
      end
      // Crystal gives nothing until enabled, then wakes after 1024 counts
      wr(OFS_IRQ_MASK, 8'h01);
      preload(16'hfc00);
      ctrl(1'b1, 2'b00, 2'b10, 1'b1, 1'b0);
      repeat (50) @(posedge clock_in);
      rd(OFS_COUNT_LOW, 32'h0, "crystal off");
      sleep <= 1'b1;
      ctrl(1'b1, 2'b00, 2'b10, 1'b1, 1'b1);
      repeat (300) @(posedge clock_in);
      check("early wake", 32'(irq), 32'h0);
      for (int n = 0; n < 30000 && irq !== 1'b1; n++)
         @(posedge clock_in);
      check("crystal wake", 32'(irq), 32'h1);
      // Second reset in mid-run
      rst_b <= 1'b0;
      repeat (2) @(posedge clock_in);
      rst_b <= 1'b1;
      sleep <= 1'b0;
      @(posedge clock_in);
      check("reset irq", 32'(irq), 32'h0);
      rd(OFS_TIMER_CTRL, 32'h0, "reset ctrl");
      conclude();
   end
endmodule

// >>> tb/timer_pins_model.sv
`timescale 1ns/10ps
module timer_pins_model #(
   parameter int unsigned EXT_HALF  = 4,
   parameter int unsigned CRYS_HALF = 4
)
(
   // Clock
   input  wire logic clock_in,
   // Bench commands
   input  wire logic ext_run_in,
   input  wire logic gate_level_in,
   // Timer pins
   input  wire logic crystal_out_pin,
   output logic      ext_clock_out,
   output logic      crystal_in_pin,
   output logic      gate_out
);
   int unsigned ext_cnt  = 0;
   int unsigned crys_cnt = 0;

   // Quiet pins at time zero
   initial begin
      ext_clock_out = 1'b0;
      crystal_in_pin = 1'b0;
      gate_out = 1'b0;
   end

   // External clock runs only inside a burst, stands low otherwise
   always @(posedge clock_in) begin
      ext_cnt <= (ext_run_in && ext_cnt < EXT_HALF - 1) ? ext_cnt + 1 : 0;
      if (!ext_run_in)
         ext_clock_out <= 1'b0;
      else if (ext_cnt == EXT_HALF - 1)
         ext_clock_out <= !ext_clock_out;
   end

   // Crystal echoes its drive late, so it never starts undriven; sleep has no say
   always @(posedge clock_in) begin
      crys_cnt <= (crys_cnt < CRYS_HALF - 1) ? crys_cnt + 1 : 0;
      if (crys_cnt == CRYS_HALF - 1)
         crystal_in_pin <= crystal_out_pin;
   end

   // Gate level chosen by the bench
   always @(posedge clock_in) begin
      gate_out <= gate_level_in;
   end
endmodule
